// File: core_event_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "perf_counters_consts.vh"

module core_event_decode (
  // Clock and reset.
  input  wire                      clk_i,
  input  wire                      rst_b_i,
  // Event reports from the core, same clock.
  input  wire                      ic_miss_i,
  input  wire                      ic_nodeliver_i,
  input  wire                      dep_stall_i,
  input  wire                      itb_miss_i,
  input  wire                      dtb_miss_i,
  input  wire                      br_exec_i,
  input  wire                      br_mispred_i,
  input  wire                      br_plain_or_link_i,
  input  wire                      instr_exec_i,
  input  wire                      buf_full_i,
  input  wire                      dc_access_i,
  input  wire                      dc_miss_i,
  input  wire                      dc_cache_op_i,
  input  wire                      dc_wback_half_i,
  input  wire                      pc_write_i,
  input  wire                      mode_change_i,
  // One bit per selection code.
  output wire [`PC_NUM_CODES-1:0]  ev_o
);

  reg buf_full_q;

  // Remembers last cycle's full-buffer stall so a run counts once.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_full_q <= 1'b0;
    end else begin
      buf_full_q <= buf_full_i;
    end
  end

  // Each bit position equals its selection code.
  assign ev_o[0]  = ic_miss_i;
  assign ev_o[1]  = ic_nodeliver_i;
  assign ev_o[2]  = dep_stall_i;
  assign ev_o[3]  = itb_miss_i;
  assign ev_o[4]  = dtb_miss_i;
  assign ev_o[5]  = br_exec_i;
  assign ev_o[6]  = br_mispred_i & br_plain_or_link_i;
  assign ev_o[7]  = instr_exec_i;
  assign ev_o[8]  = buf_full_i;
  assign ev_o[9]  = buf_full_i & ~buf_full_q;
  assign ev_o[10] = dc_access_i & ~dc_cache_op_i;
  assign ev_o[11] = dc_miss_i & ~dc_cache_op_i;
  assign ev_o[12] = dc_wback_half_i;
  assign ev_o[13] = pc_write_i & ~mode_change_i;

endmodule // core_event_decode
`default_nettype wire

// File: core_event_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_event_model (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Event pattern wanted for the next cycle.
  input  wire logic [15:0] req_i,
  // Event reports towards the counters.
  output var  logic [15:0] ev_o
);
  // Reports leave on a clock edge like the pipeline's own status flops, so the counters never see a glitch.
  // The pipeline is quiet in reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ev_o <= 16'h0000;
    end else begin
      ev_o <= req_i;
    end
  end
endmodule // core_event_model

`default_nettype wire

// File: core_perf_event_counters.v
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "perf_counters_consts.vh"

module core_perf_event_counters (
  // Clock and reset.
  input  wire         CLOCK_I,
  input  wire         RST_B_I,
  // AHB-Lite slave.
  input  wire         HSEL_I,
  input  wire [31:0]  HADDR_I,
  input  wire [1:0]   HTRANS_I,
  input  wire         HWRITE_I,
  input  wire [2:0]   HSIZE_I,
  input  wire [31:0]  HWDATA_I,
  input  wire         HREADY_I,
  output reg  [31:0]  HRDATA_O,
  output reg          HREADYOUT_O,
  output reg          HRESP_O,
  // Core pipeline and cache event reports, same clock.
  input  wire         IC_MISS_I,
  input  wire         IC_NODELIVER_I,
  input  wire         DEP_STALL_I,
  input  wire         ITB_MISS_I,
  input  wire         DTB_MISS_I,
  input  wire         BR_EXEC_I,
  input  wire         BR_MISPRED_I,
  input  wire         BR_PLAIN_OR_LINK_I,
  input  wire         INSTR_EXEC_I,
  input  wire         BUF_FULL_I,
  input  wire         DC_ACCESS_I,
  input  wire         DC_MISS_I,
  input  wire         DC_CACHE_OP_I,
  input  wire         DC_WBACK_HALF_I,
  input  wire         PC_WRITE_I,
  input  wire         MODE_CHANGE_I,
  // Counter overflow interrupt for sampling.
  output reg          OVF_IRQ_O
);

  // Selects one event line by code; unknown codes give no count.
  // Codes past the table are handled here, so every counter treats them alike.
  function sel_event;
    input [`PC_NUM_CODES-1:0] ev;
    input [`PC_EVSEL_W-1:0]   code;
    begin
      if (code < `PC_NUM_CODES) begin
        sel_event = ev[code[3:0]];
      end else begin
        sel_event = 1'b0;
      end
    end
  endfunction

  // Matches a word address against a register offset.
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // Matches a word address against the slot of event counter idx; the slots are consecutive words.
  function slot_hit;
    input [7:0]   addr;
    input integer idx;
    begin
      slot_hit = (addr[7:2] == (`PC_OFS_EVCNT0 >> 2) + idx);
    end
  endfunction

  // Bus phase state.
  reg                        wr_pend_q;
  reg  [7:0]                 wr_addr_q;

  // Software-visible configuration.
  reg  [31:0]                ctrl_q;
  reg  [31:0]                evsel_q;
  reg                        clr_pulse_q;

  // Clock divider.
  reg  [`PC_DIV_W-1:0]       div_q;
  reg  [`PC_DIV_W-1:0]       div_d;

  // Counter plumbing.
  wire [`PC_NUM_CODES-1:0]   ev_vec;
  wire                       count_en;
  wire                       div_en;
  wire                       div_tick;
  wire                       clk_inc;
  wire [`PC_CNT_W-1:0]       clk_count;
  wire                       clk_ovf;
  wire [`PC_NUM_EV-1:0]      ev_inc;
  wire [`PC_NUM_EV-1:0]      ev_ld;
  wire [`PC_NUM_EV-1:0]      ev_ovf;
  wire [`PC_CNT_W*`PC_NUM_EV-1:0] ev_count;
  wire [`PC_OVF_MSB:0]       ovf_all;
  wire [`PC_OVF_MSB:0]       ovf_clr;
  wire [`PC_CNT_W-1:0]       ld_val;
  wire                       clk_ld;
  wire                       addr_phase;
  wire                       wr_do;
  reg  [31:0]                rd_mux;

  // Bus decode, per-register write strobes and the interrupt mask.
  wire                       addr_ok;
  wire                       rd_take;
  wire                       wr_take;
  wire                       wr_ctrl;
  wire                       wr_ovf;
  wire                       wr_evsel;
  wire                       wr_clk;
  wire [`PC_OVF_MSB:0]       irq_en;

  assign count_en = ctrl_q[`PC_CTRL_EN_BIT];
  assign div_en   = ctrl_q[`PC_CTRL_DIV_BIT];

  // An AHB transfer is taken when selected, non-idle and the bus is ready.
  // Only the low byte picks a register, so the upper bits must be zero for a hit;
  // otherwise writes to far addresses would alias onto the registers.
  assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign addr_ok    = (HADDR_I[31:8] == 24'h000000);
  assign rd_take    = addr_phase & ~HWRITE_I;
  assign wr_take    = addr_phase & HWRITE_I & addr_ok;
  assign wr_do      = wr_pend_q;

  // Write strobes, decoded once from the stored address and valid in the data phase.
  // HWDATA_I holds the word only in that cycle, so every register loads then.
  assign wr_ctrl  = wr_do & hit(wr_addr_q, `PC_OFS_CTRL);
  assign wr_ovf   = wr_do & hit(wr_addr_q, `PC_OFS_OVF);
  assign wr_evsel = wr_do & hit(wr_addr_q, `PC_OFS_EVSEL);
  assign wr_clk   = wr_do & hit(wr_addr_q, `PC_OFS_CLKCNT);

  // Data phase bookkeeping; the slave never inserts wait states.
  // Ready and response are registered constants, so they cannot glitch after reset.
  // A write with nonzero upper address bits never raises the pending flag and is dropped.
  always @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      wr_pend_q   <= wr_take;
      if (addr_phase) begin
        wr_addr_q <= HADDR_I[7:0];
      end
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // Read data is captured at the end of the address phase so it stands during the data phase.
  // A read therefore returns a count as it stood one cycle before the data phase.
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit(HADDR_I[7:0], `PC_OFS_CTRL)) begin
      rd_mux = ctrl_q & 32'h0000_01f3;
    end else if (hit(HADDR_I[7:0], `PC_OFS_OVF)) begin
      rd_mux = {27'h0000000, ovf_all};
    end else if (hit(HADDR_I[7:0], `PC_OFS_EVSEL)) begin
      rd_mux = evsel_q;
    end else if (hit(HADDR_I[7:0], `PC_OFS_CLKCNT)) begin
      rd_mux = clk_count;
    end else if (hit(HADDR_I[7:0], `PC_OFS_EVCNT0)) begin
      rd_mux = ev_count[31:0];
    end else if (hit(HADDR_I[7:0], `PC_OFS_EVCNT1)) begin
      rd_mux = ev_count[63:32];
    end else if (hit(HADDR_I[7:0], `PC_OFS_EVCNT2)) begin
      rd_mux = ev_count[95:64];
    end else if (hit(HADDR_I[7:0], `PC_OFS_EVCNT3)) begin
      rd_mux = ev_count[127:96];
    end
    if (!addr_ok) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data register; unmapped words read as zero.
  // Holding the word between reads keeps the data phase stable whatever the bus does next.
  always @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (rd_take) begin
      HRDATA_O <= rd_mux;
    end
  end

  // Control and selection registers; the clear bit is a one-cycle pulse, never stored.
  // Keeping the clear out of the register means a control read never shows a stale request.
  always @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_q      <= `PC_CTRL_RESET;
      evsel_q     <= `PC_EVSEL_RESET;
      clr_pulse_q <= 1'b0;
    end else begin
      clr_pulse_q <= 1'b0;
      if (wr_ctrl) begin
        ctrl_q      <= HWDATA_I & 32'h0000_01f3;
        clr_pulse_q <= HWDATA_I[`PC_CTRL_CLR_BIT];
      end
      if (wr_evsel) begin
        evsel_q <= HWDATA_I;
      end
    end
  end

  // Prescaler runs only while counting is enabled with the divider on.
  // Holding it at zero while off puts the first divided count a full 64 cycles after enable.
  // The cost is that a short burst of divided counting can end with no count at all.
  always @* begin
    div_d = div_q;
    if (count_en && div_en) begin
      div_d = div_q + 6'h01;
    end else begin
      div_d = 6'h00;
    end
  end

  // Prescaler register.
  always @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_d;
    end
  end

  // The divider wraps at 63, giving one tick per 64 cycles.
  assign div_tick = (div_q == `PC_DIV_LAST);
  assign clk_inc  = count_en & (div_en ? div_tick : 1'b1);

  // Load value: the clear pulse zeroes, a bus write loads the written word.
  // A load wins over a count in the same cycle, so software reads back exactly what it wrote.
  assign ld_val = clr_pulse_q ? 32'h0000_0000 : HWDATA_I;
  assign clk_ld = clr_pulse_q | wr_clk;

  // Overflow flags clear by writing ones to the status register.
  // Zeros leave flags alone, so software can clear one flag without racing the others.
  assign ovf_clr = wr_ovf ? HWDATA_I[`PC_OVF_MSB:0] : 5'h00;
  assign ovf_all = {ev_ovf, clk_ovf};

  // Event lines from the core, decoded to selection codes.
  // The decoder keeps the one piece of history needed to count stall runs.
  // The lines arrive on this clock, so no synchroniser stands in front of it.
  core_event_decode u_decode (
    .clk_i              (CLOCK_I),
    .rst_b_i            (RST_B_I),
    .ic_miss_i          (IC_MISS_I),
    .ic_nodeliver_i     (IC_NODELIVER_I),
    .dep_stall_i        (DEP_STALL_I),
    .itb_miss_i         (ITB_MISS_I),
    .dtb_miss_i         (DTB_MISS_I),
    .br_exec_i          (BR_EXEC_I),
    .br_mispred_i       (BR_MISPRED_I),
    .br_plain_or_link_i (BR_PLAIN_OR_LINK_I),
    .instr_exec_i       (INSTR_EXEC_I),
    .buf_full_i         (BUF_FULL_I),
    .dc_access_i        (DC_ACCESS_I),
    .dc_miss_i          (DC_MISS_I),
    .dc_cache_op_i      (DC_CACHE_OP_I),
    .dc_wback_half_i    (DC_WBACK_HALF_I),
    .pc_write_i         (PC_WRITE_I),
    .mode_change_i      (MODE_CHANGE_I),
    .ev_o               (ev_vec)
  );

  // Clock counter; loading 2^32 minus N gives an overflow after N counts.
  // Software keeps the tally of wraps; the counter itself has no upper word.
  // A zero interval is not possible: loading zero waits a full 2^32 counts.
  perf_counter32 u_clk_cnt (
    .clk_i     (CLOCK_I),
    .rst_b_i   (RST_B_I),
    .inc_i     (clk_inc),
    .ld_i      (clk_ld),
    .ld_val_i  (ld_val),
    .ovf_clr_i (ovf_clr[`PC_OVF_CLK_BIT]),
    .count_o   (clk_count),
    .ovf_o     (clk_ovf)
  );

  // Four event counters, each fed by its own selection byte.
  // An unused code feeds nothing, so a parked counter keeps its value for later reads.
  genvar gi;
  generate
    for (gi = 0; gi < `PC_NUM_EV; gi = gi + 1) begin : g_ev
      assign ev_inc[gi] = count_en & sel_event(ev_vec, evsel_q[gi*8 +: 8]);
      assign ev_ld[gi]  = clr_pulse_q | (wr_do & slot_hit(wr_addr_q, gi));
      perf_counter32 u_ev_cnt (
        .clk_i     (CLOCK_I),
        .rst_b_i   (RST_B_I),
        .inc_i     (ev_inc[gi]),
        .ld_i      (ev_ld[gi]),
        .ld_val_i  (ld_val),
        .ovf_clr_i (ovf_clr[`PC_OVF_EV_LSB + gi]),
        .count_o   (ev_count[gi*32 +: 32]),
        .ovf_o     (ev_ovf[gi])
      );
    end
  endgenerate

  // Interrupt enable field, one bit per overflow flag in the same order.
  assign irq_en = ctrl_q[`PC_CTRL_IE_MSB:`PC_CTRL_IE_LSB];

  // Interrupt when any enabled overflow flag stands; software keeps the overflow tally.
  // The enables mask only the line, never the flags, so polling software still sees every wrap.
  always @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      OVF_IRQ_O <= 1'b0;
    end else begin
      OVF_IRQ_O <= |(ovf_all & irq_en);
    end
  end

endmodule // core_perf_event_counters
`default_nettype wire

// File: core_perf_event_counters_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_counters_consts.vh"

module perf_counters_checker (
  // Clock and reset.
  input wire logic        CLOCK_I,
  input wire logic        RST_B_I,
  // Bus and interrupt.
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        OVF_IRQ_O
);
  logic       take;
  logic       rd;
  logic       wr_ctrl_q;
  logic [4:0] ie_q;

  // Address phases accepted at this edge.
  assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign rd   = take && !HWRITE_I;

  // Shadow of the interrupt enables, because a masked flag must keep the line low.
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_ctrl_q <= 1'b0;
      ie_q      <= 5'h00;
    end else begin
      wr_ctrl_q <= take && HWRITE_I && HADDR_I[31:2] == 30'h0000_0000;
      if (wr_ctrl_q) begin
        ie_q <= HWDATA_I[8:4];
      end
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);

  property p_rdy; HREADYOUT_O; endproperty
  a_rdy: assert property (p_rdy) else $error("slave inserted a wait state");
  property p_okay; !HRESP_O; endproperty
  a_okay: assert property (p_okay) else $error("slave answered with an error");
  property p_unmapped; rd && (HADDR_I[31:8] != 24'h0 || HADDR_I[7:2] > (`PC_OFS_EVCNT3 >> 2)) |=> HRDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !rd |=> $stable(HRDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_ctrl_res; rd && HADDR_I == 32'h0 |=> HRDATA_O[31:9] == 23'h0 && !HRDATA_O[3]; endproperty
  a_ctrl_res: assert property (p_ctrl_res) else $error("control spare bits not zero");
  property p_clr_rd; rd && HADDR_I == 32'h0 |=> !HRDATA_O[2]; endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear bit read back high");
  property p_ovf_res; rd && HADDR_I == 32'h4 |=> HRDATA_O[31:5] == 27'h0; endproperty
  a_ovf_res: assert property (p_ovf_res) else $error("overflow spare bits not zero");
  property p_irq_mask; ie_q == 5'h00 && $past(ie_q) == 5'h00 |-> !OVF_IRQ_O; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt high while masked");
endmodule // perf_counters_checker

bind core_perf_event_counters perf_counters_checker u_chk (.CLOCK_I, .RST_B_I, .HSEL_I, .HADDR_I, .HTRANS_I,
  .HWRITE_I, .HWDATA_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .OVF_IRQ_O);

`default_nettype wire

// File: perf_counter32.v
`timescale 1ns/1ps
`default_nettype none
`include "perf_counters_consts.vh"

module perf_counter32 (
  // Clock and reset.
  input  wire                   clk_i,
  input  wire                   rst_b_i,
  // Count and load control.
  input  wire                   inc_i,
  input  wire                   ld_i,
  input  wire [`PC_CNT_W-1:0]   ld_val_i,
  input  wire                   ovf_clr_i,
  // State.
  output reg  [`PC_CNT_W-1:0]   count_o,
  output reg                    ovf_o
);

  wire wrap = inc_i & ~ld_i & (&count_o);

  // A load wins over an increment in the same cycle; software owns the value then.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_o <= 32'h0000_0000;
      ovf_o   <= 1'b0;
    end else begin
      if (ld_i) begin
        count_o <= ld_val_i;
      end else if (inc_i) begin
        count_o <= count_o + 32'h0000_0001;
      end
      // The wrap sets the flag even when software clears it in that cycle.
      if (wrap) begin
        ovf_o <= 1'b1;
      end else if (ovf_clr_i) begin
        ovf_o <= 1'b0;
      end
    end
  end

endmodule // perf_counter32
`default_nettype wire

// File: perf_counters_consts.vh
`ifndef PERF_COUNTERS_CONSTS_VH
`define PERF_COUNTERS_CONSTS_VH

// Register byte offsets on the AHB-Lite bus.
`define PC_OFS_CTRL        8'h00
`define PC_OFS_OVF         8'h04
`define PC_OFS_EVSEL       8'h08
`define PC_OFS_CLKCNT      8'h0c
`define PC_OFS_EVCNT0      8'h10
`define PC_OFS_EVCNT1      8'h14
`define PC_OFS_EVCNT2      8'h18
`define PC_OFS_EVCNT3      8'h1c

// Control register fields.
`define PC_CTRL_EN_BIT     0
`define PC_CTRL_DIV_BIT    1
`define PC_CTRL_CLR_BIT    2
`define PC_CTRL_IE_LSB     4
`define PC_CTRL_IE_MSB     8
`define PC_CTRL_RESET      32'h0000_0000

// Overflow status fields: bit 0 clock counter, bits 1..4 event counters.
`define PC_OVF_CLK_BIT     0
`define PC_OVF_EV_LSB      1
`define PC_OVF_MSB         4

// Event selection: one byte per event counter.
`define PC_EVSEL_W         8
`define PC_EVSEL_RESET     32'hffff_ffff

// Counter geometry.
`define PC_CNT_W           32
`define PC_NUM_EV          4
`define PC_NUM_CODES       14

// Clock divider: one clock count per 64 processor cycles.
`define PC_DIV_RATIO       64
`define PC_DIV_W           6
`define PC_DIV_LAST        6'h3f

// Event selection codes.
`define PC_EV_IC_MISS      8'h00
`define PC_EV_IC_NODELIVER 8'h01
`define PC_EV_DEP_STALL    8'h02
`define PC_EV_ITB_MISS     8'h03
`define PC_EV_DTB_MISS     8'h04
`define PC_EV_BR_EXEC      8'h05
`define PC_EV_BR_MISPRED   8'h06
`define PC_EV_INSTR_EXEC   8'h07
`define PC_EV_BUF_FULL_CYC 8'h08
`define PC_EV_BUF_FULL_RUN 8'h09
`define PC_EV_DC_ACCESS    8'h0a
`define PC_EV_DC_MISS      8'h0b
`define PC_EV_DC_WBACK     8'h0c
`define PC_EV_SW_PC        8'h0d

`endif

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_counters_consts.vh"

module testbench;
  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic        hwrite;
  logic        hrdy;
  logic        hresp;
  logic        irq;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [15:0] req;
  logic [15:0] ev;
  int          n_fail;
  int          n_tests;

  core_perf_event_counters DUT (.CLOCK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy),
    .HRESP_O(hresp), .IC_MISS_I(ev[0]), .IC_NODELIVER_I(ev[1]), .DEP_STALL_I(ev[2]), .ITB_MISS_I(ev[3]),
    .DTB_MISS_I(ev[4]), .BR_EXEC_I(ev[5]), .BR_MISPRED_I(ev[6]), .BR_PLAIN_OR_LINK_I(ev[7]), .INSTR_EXEC_I(ev[8]),
    .BUF_FULL_I(ev[9]), .DC_ACCESS_I(ev[10]), .DC_MISS_I(ev[11]), .DC_CACHE_OP_I(ev[12]), .DC_WBACK_HALF_I(ev[13]),
    .PC_WRITE_I(ev[14]), .MODE_CHANGE_I(ev[15]), .OVF_IRQ_O(irq));
  core_event_model u_core (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .ev_o(ev));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready is sampled at each rising edge, as the slave's flops see it; a stuck bus ends the run.
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hrdy !== 1'b1 && k < 16) begin
      @(posedge clk);
      k++;
    end
    if (hrdy !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask

  // One single word transfer; called just after a rising edge and returns just after the data phase edge.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, {24'h0, a}, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, {24'h0, a}, 32'h0, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge clk);
    chk("interrupt", {31'h0, irq}, {31'h0, exp});
    @(posedge clk);
  endtask

  // Three cycles of the event behind a code, with its qualifier or exclusion present in only some of them.
  task automatic pulse(input logic [7:0] c);
    int n;
    logic [15:0] b;
    b = 16'h0001 << ((c == 8'h07) ? 8 : (c == 8'h08) ? 9 : (c >= 8'h0c) ? c + 1 : c);
    for (n = 0; n < 3; n++) begin
      req <= b | ((c == 8'h06 && n > 0) ? 16'h0080 : 16'h0000) | ((n == 0 && (c == 8'h0a || c == 8'h0b)) ?
             16'h1000 : 16'h0000) | ((n == 0 && c == 8'h0d) ? 16'h8000 : 16'h0000);
      @(posedge clk);
    end
    req <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    int i;
    logic [31:0] v;
    rdc("ctrl", `PC_OFS_CTRL, `PC_CTRL_RESET);
    rdc("ovf", `PC_OFS_OVF, 32'h0);
    rdc("evsel", `PC_OFS_EVSEL, `PC_EVSEL_RESET);
    rdc("clock counter", `PC_OFS_CLKCNT, 32'h0);
    for (i = 0; i < `PC_NUM_EV; i++) begin
      rdc("event counter", 8'(`PC_OFS_EVCNT0 + 4 * i), 32'h0);
    end
    wr(8'h40, 32'h1234_5678);
    rdc("unmapped", 8'h40, 32'h0);
    xfer(1'b1, 32'h0000_0100, 32'h0000_0001, v);
    rdc("ctrl alias", `PC_OFS_CTRL, `PC_CTRL_RESET);
    $display("reset test done");
  endtask

  task automatic t_clock();
    logic [31:0] a;
    logic [31:0] b;
    int k;
    wr(`PC_OFS_CTRL, 32'h0000_0001);
    rd(`PC_OFS_CLKCNT, a);
    rd(`PC_OFS_CLKCNT, b);
    chk("clock step", b - a, 32'h2);
    wr(`PC_OFS_CTRL, 32'h0000_0003);
    rd(`PC_OFS_CLKCNT, a);
    for (k = 0; k < 3; k++) begin
      repeat (`PC_DIV_RATIO - 2) @(posedge clk);
      rd(`PC_OFS_CLKCNT, b);
      chk("divided step", b - a, 32'h1);
      a = b;
    end
    $display("clock test done");
  endtask

  task automatic t_events();
    logic [7:0] c;
    int i;
    int exp;
    for (i = 0; i < `PC_NUM_CODES; i++) begin
      c = 8'(i);
      wr(`PC_OFS_EVSEL, {8'h0e, c, 8'hff, c});
      wr(`PC_OFS_CTRL, 32'h0000_0005);
      pulse(c);
      exp = (c == 8'h09) ? 1 : (c == 8'h06 || c == 8'h0a || c == 8'h0b || c == 8'h0d) ? 2 : 3;
      rdc("event counter 0", `PC_OFS_EVCNT0, 32'(exp));
      rdc("event counter 2", `PC_OFS_EVCNT2, 32'(exp));
      rdc("event counter 1", `PC_OFS_EVCNT1, 32'h0);
      rdc("event counter 3", `PC_OFS_EVCNT3, 32'h0);
    end
    $display("event test done");
  endtask

  task automatic t_ovf();
    logic [31:0] o;
    logic [31:0] v;
    wr(`PC_OFS_CTRL, 32'h0000_0031);
    wr(`PC_OFS_EVSEL, 32'hffff_ff05);
    wr(`PC_OFS_EVCNT0, 32'hffff_fffe);
    wr(`PC_OFS_CLKCNT, 32'hffff_fff0);
    rdc("ovf early", `PC_OFS_OVF, 32'h0);
    pulse(8'h05);
    repeat (12) @(posedge clk);
    rdc("ovf both", `PC_OFS_OVF, 32'h3);
    rdc("wrapped counter", `PC_OFS_EVCNT0, 32'h1);
    rd(`PC_OFS_OVF, o);
    rd(`PC_OFS_EVCNT0, v);
    chk("event total", 32'({31'h0, o[1], v} - 64'hffff_fffe), 32'h3);
    irq_chk(1'b1);
    wr(`PC_OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    irq_chk(1'b0);
    wr(`PC_OFS_OVF, 32'h0000_0001);
    rdc("ovf one cleared", `PC_OFS_OVF, 32'h2);
    wr(`PC_OFS_CTRL, 32'h0000_0021);
    repeat (2) @(posedge clk);
    irq_chk(1'b1);
    wr(`PC_OFS_OVF, 32'h0000_0002);
    repeat (2) @(posedge clk);
    irq_chk(1'b0);
    rdc("ovf cleared", `PC_OFS_OVF, 32'h0);
    $display("overflow test done");
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    req = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_clock();
    t_events();
    t_ovf();
    stop_test();
  end
endmodule // testbench

`default_nettype wire
